// ===== hw/usr_rx_top.v
// Purpose: receive path of a synchronous serial port, slave and master
// Assumes: 100 MHz clock; shift clock pin and data pin are asynchronous
// Notes:   data sampled on falling edges of the shift clock, lsb first
//
// Notes on behaviour
// - slave mode behaves like master mode except during sleep and for single receive
// - single-receive enable has no effect in slave mode
// - continuous receive keeps working in slave mode while the core sleeps
// - completed word moves from shift register to holding register unless the previous word is still unread
// - completed word with receive interrupt enabled wakes the core
// - with global and peripheral enables set the core branches to vector 0004h
// - ninth-bit receive enable selects 9-bit words
// - slave reception starts only once continuous receive is set
// - each word sets the receive flag; interrupt if enabled
// - status register shows ninth bit and overrun error; framing bit reads 0
// - holding register read returns the low eight bits
// - clearing continuous receive clears a pending error
// - core interrupt needs both global and peripheral enables
// - cleared clock source select means slave mode
`timescale 1ns/100ps
`include "usr_consts.vh"

module usr_rx_top
(
    input  wire                   clock,
    input  wire                   rst,
    input  wire [`USR_ADDR_W-1:0] addr,
    input  wire [`USR_DATA_W-1:0] wdata,
    input  wire                   wr_en,
    input  wire                   rd_en,
    output reg  [`USR_DATA_W-1:0] rdata,
    input  wire                   transmit_clock_pin_in,
    input  wire                   data_pin_in,
    input  wire                   core_sleep,
    output reg                    transmit_clock_pin_out,
    output reg                    transmit_clock_pin_oe,
    output reg                    rx_wake,
    output reg                    core_irq,
    output reg  [`USR_VEC_W-1:0]  irq_vector
);

    // software registers
    reg [7:0] interrupt_master_control;
    reg [7:0] peripheral_enable_set_one;
    reg [7:0] transmit_status_control;
    reg [7:0] baud_divider;
    reg       serial_port_enable;
    reg       ninth_bit_receive_enable;
    reg       single_receive_enable;
    reg       continuous_receive_enable;
    reg       address_detect_enable;

    // receive state
    reg [8:0] receive_shift_register;
    reg [3:0] bit_cnt;
    reg [7:0] receive_holding_register;
    reg       received_ninth_bit;
    reg       receive_interrupt_flag;
    reg       overrun_error;

    // shift clock handling
    wire [1:0] pins_sync;
    reg        clk_prev;
    reg        master_clk;
    reg [7:0]  baud_cnt;

    wire clock_source_select = transmit_status_control[`USR_BIT_CLOCK_SOURCE_SELECT];
    wire sync_mode           = transmit_status_control[`USR_BIT_SYNC];
    wire master_mode         = clock_source_select;
    wire slave_mode          = !clock_source_select;
    wire port_on             = serial_port_enable & sync_mode;

    // single_receive_enable only matters in master mode
    wire rx_request = slave_mode ? continuous_receive_enable
                    : (continuous_receive_enable | single_receive_enable);
    // an overrun halts shifting until continuous receive is cleared
    wire rx_run     = port_on & rx_request & !overrun_error;

    wire read_hit   = rd_en & (addr == `USR_OFS_RX_DATA);
    wire flag_read  = rd_en & (addr == `USR_OFS_FLAGS);
    wire flag_clear = read_hit | flag_read;

    // the pin clock only counts in slave mode; the master clock is ours
    wire clk_now    = master_mode ? master_clk : !pins_sync[1];
    wire data_now   = pins_sync[0];
    wire fall_edge  = clk_prev & !clk_now;
    wire shift_now  = rx_run & fall_edge;

    wire [8:0] next_shift = {data_now, receive_shift_register[8:1]};
    wire [3:0] last_bit   = ninth_bit_receive_enable ? `USR_BITS_9
                          : `USR_BITS_8;
    wire word_done  = shift_now & (bit_cnt == last_bit);
    wire unread     = receive_interrupt_flag & !read_hit;

    // in 8-bit mode the word has only reached bits 8:1
    wire [7:0] word_low = ninth_bit_receive_enable ? next_shift[7:0]
                        : next_shift[8:1];
    wire word_ninth = ninth_bit_receive_enable & next_shift[8];

    // set wins: a word completing beside a data or flag register read keeps the flag
    wire next_flag = word_done
                   | (receive_interrupt_flag & !flag_clear);

    wire flag_enabled = peripheral_enable_set_one[`USR_BIT_RX_FLAG];
    wire next_wake    = next_flag & flag_enabled;
    wire next_irq     = next_wake
                      & interrupt_master_control[`USR_BIT_GIE]
                      & interrupt_master_control[`USR_BIT_PERIPHERAL_INTERRUPT_ENABLE];

    // clock pin enters inverted, so the reset value of 0 reads as idle high
    usr_sync2
    #(
        .WIDTH      (2)
    )
    u_pin_sync
    (
        .clock      (clock),
        .rst        (rst),
        .async_in   ({~transmit_clock_pin_in, data_pin_in}),
        .sync_out   (pins_sync)
    );

    // master-mode shift clock from the baud divider; the oscillator
    // stops in sleep, so only a slave keeps receiving there
    always @(posedge clock)
    begin
        if (rst)
        begin
            master_clk <= 1'b1;
            baud_cnt   <= 8'h00;
        end
        else if (!(master_mode & rx_run) | core_sleep)
        begin
            master_clk <= 1'b1;
            baud_cnt   <= 8'h00;
        end
        else if (baud_cnt == baud_divider)
        begin
            master_clk <= !master_clk;
            baud_cnt   <= 8'h00;
        end
        else
        begin
            baud_cnt <= baud_cnt + 8'h01;
        end
    end

    // the pin is driven only when we are the clock master
    always @(posedge clock)
    begin
        if (rst)
        begin
            transmit_clock_pin_out <= 1'b1;
            transmit_clock_pin_oe  <= 1'b0;
            clk_prev               <= 1'b1;
        end
        else
        begin
            transmit_clock_pin_out <= master_clk;
            transmit_clock_pin_oe  <= port_on & master_mode;
            clk_prev               <= clk_now;
        end
    end

    // software-owned control bits
    always @(posedge clock)
    begin
        if (rst)
        begin
            interrupt_master_control  <= `USR_RST_IRQ_CTL;
            peripheral_enable_set_one <= `USR_RST_ENABLES;
            transmit_status_control   <= `USR_RST_TX_STAT;
            baud_divider              <= `USR_RST_BAUD;
            serial_port_enable        <= 1'b0;
            ninth_bit_receive_enable  <= 1'b0;
            single_receive_enable     <= 1'b0;
            continuous_receive_enable <= 1'b0;
            address_detect_enable     <= 1'b0;
        end
        else if (wr_en)
        begin
            case (addr)
                `USR_OFS_IRQ_CTL:
                    interrupt_master_control <= wdata;
                `USR_OFS_ENABLES:
                    peripheral_enable_set_one <= wdata;
                `USR_OFS_TX_STAT:
                    transmit_status_control <=
                        (wdata & `USR_TX_STAT_WMASK)
                        | `USR_RST_TX_STAT;
                `USR_OFS_BAUD:
                    baud_divider <= wdata;
                `USR_OFS_RX_STAT:
                begin
                    serial_port_enable        <= wdata[`USR_BIT_SERIAL_PORT_ENABLE];
                    ninth_bit_receive_enable  <= wdata[`USR_BIT_RX9];
                    single_receive_enable     <= wdata[`USR_BIT_SINGLE_RECEIVE_ENABLE];
                    continuous_receive_enable <= wdata[`USR_BIT_CONTINUOUS_RECEIVE_ENABLE];
                    address_detect_enable     <= wdata[`USR_BIT_ADDR_EN];
                end
                default:
                    baud_divider <= baud_divider;
            endcase
            // an unrelated write must not keep a single reception alive
            if (word_done & master_mode & !continuous_receive_enable
                & (addr != `USR_OFS_RX_STAT))
                single_receive_enable <= 1'b0;
        end
        else if (word_done & master_mode & !continuous_receive_enable)
        begin
            // a single master reception ends after one word
            single_receive_enable <= 1'b0;
        end
    end

    // shift register, bit counter and holding register
    always @(posedge clock)
    begin
        if (rst)
        begin
            receive_shift_register <= 9'h000;
            bit_cnt                <= 4'h0;
        end
        else if (!rx_run)
        begin
            receive_shift_register <= 9'h000;
            bit_cnt                <= 4'h0;
        end
        else if (word_done)
        begin
            receive_shift_register <= 9'h000;
            bit_cnt                <= 4'h0;
        end
        else if (shift_now)
        begin
            receive_shift_register <= next_shift;
            bit_cnt                <= bit_cnt + 4'h1;
        end
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            receive_holding_register <= `USR_RST_RX_DATA;
            received_ninth_bit       <= 1'b0;
        end
        else if (word_done & !unread)
        begin
            receive_holding_register <= word_low;
            received_ninth_bit       <= word_ninth;
        end
    end

    // overrun: set wins, and only clearing continuous receive clears it
    always @(posedge clock)
    begin
        if (rst)
        begin
            overrun_error <= 1'b0;
        end
        else if (word_done & unread)
        begin
            overrun_error <= 1'b1;
        end
        else if (!continuous_receive_enable)
        begin
            overrun_error <= 1'b0;
        end
    end

    // receive flag: sticky, cleared by reading data or the flag register
    always @(posedge clock)
    begin
        if (rst)
        begin
            receive_interrupt_flag <= 1'b0;
        end
        else
        begin
            receive_interrupt_flag <= next_flag;
        end
    end

    // wake is independent of the global enable, the branch is not
    always @(posedge clock)
    begin
        if (rst)
        begin
            rx_wake    <= 1'b0;
            core_irq   <= 1'b0;
            irq_vector <= {`USR_VEC_W{1'b0}};
        end
        else
        begin
            rx_wake    <= next_wake;
            core_irq   <= next_irq;
            irq_vector <= next_irq ? `USR_IRQ_VECTOR
                        : {`USR_VEC_W{1'b0}};
        end
    end

    // read data stands for exactly one cycle after the strobe
    always @(posedge clock)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (rd_en)
        begin
            case (addr)
                `USR_OFS_IRQ_CTL:
                    rdata <= interrupt_master_control;
                `USR_OFS_FLAGS:
                    rdata <= {2'h0, receive_interrupt_flag, 5'h00};
                `USR_OFS_RX_STAT:
                    rdata <= {serial_port_enable,
                              ninth_bit_receive_enable,
                              single_receive_enable,
                              continuous_receive_enable,
                              address_detect_enable,
                              1'b0,
                              overrun_error,
                              received_ninth_bit};
                `USR_OFS_RX_DATA:
                    rdata <= receive_holding_register;
                `USR_OFS_ENABLES:
                    rdata <= peripheral_enable_set_one;
                `USR_OFS_TX_STAT:
                    rdata <= transmit_status_control;
                `USR_OFS_BAUD:
                    rdata <= baud_divider;
                default:
                    rdata <= 8'h00;
            endcase
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

endmodule // usr_rx_top

// ===== hw/usr_consts.vh
// Purpose: constants of the synchronous receive port
// Assumes: byte-wide register port, one register per printed offset
// Notes:   offsets are the printed register addresses
`ifndef USR_CONSTS_VH
`define USR_CONSTS_VH

`define USR_ADDR_W          8
`define USR_DATA_W          8

`define USR_OFS_IRQ_CTL     8'h0b
`define USR_OFS_FLAGS       8'h0c
`define USR_OFS_RX_STAT     8'h18
`define USR_OFS_RX_DATA     8'h1a
`define USR_OFS_ENABLES     8'h8c
`define USR_OFS_TX_STAT     8'h98
`define USR_OFS_BAUD        8'h99

`define USR_RST_IRQ_CTL     8'h00
`define USR_RST_FLAGS       8'h00
`define USR_RST_RX_STAT     8'h00
`define USR_RST_RX_DATA     8'h00
`define USR_RST_ENABLES     8'h00
`define USR_RST_TX_STAT     8'h02
`define USR_RST_BAUD        8'h00

// interrupt_master_control
`define USR_BIT_GIE         7
`define USR_BIT_PERIPHERAL_INTERRUPT_ENABLE        6
// peripheral_flag_set_one and peripheral_enable_set_one
`define USR_BIT_RX_FLAG     5
// receive_status_control
`define USR_BIT_SERIAL_PORT_ENABLE        7
`define USR_BIT_RX9         6
`define USR_BIT_SINGLE_RECEIVE_ENABLE        5
`define USR_BIT_CONTINUOUS_RECEIVE_ENABLE        4
`define USR_BIT_ADDR_EN     3
`define USR_BIT_FRAMING_ERROR        2
`define USR_BIT_OVERRUN_ERROR        1
`define USR_BIT_RECEIVED_NINTH_BIT        0
// transmit_status_control
`define USR_BIT_CLOCK_SOURCE_SELECT        7
`define USR_BIT_SYNC        4
`define USR_BIT_TRMT        1
`define USR_TX_STAT_WMASK   8'hf5

`define USR_IRQ_VECTOR      13'h0004
`define USR_VEC_W           13
`define USR_BITS_8          4'h7
`define USR_BITS_9          4'h8

`endif

// ===== hw/usr_sync2.v
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps

module usr_sync2
#(
    parameter WIDTH = 2
)
(
    input  wire             clock,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    always @(posedge clock)
    begin
        if (rst)
        begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // usr_sync2

// ===== verif/usr_rx_master_model.sv
// Purpose: behavioural external master feeding the slave receiver
// Assumes: shift clock idles high, bit period 125 ns
// Notes:   data line shows the inverse of the last bit between frames
`timescale 1ns/100ps

module usr_rx_master_model
(
    output reg ck,
    output reg dt
);
    initial
    begin
        ck = 1'b1;
        dt = 1'b0;
    end

    // lsb first, ninth bit last; the port samples on the falling edge
    task send(input [8:0] w, input integer n);
        integer i;
    begin
        for (i = 0; i < n; i = i + 1)
        begin
            dt = w[i];
            #40 ck = 1'b0;
            #62.5 ck = 1'b1;
            #22.5;
        end
        // a released line must not pass for a held bit
        dt = ~dt;
    end
    endtask

    // fixed data level for receptions clocked by the port itself
    task hold(input b);
    begin
        dt = b;
    end
    endtask
endmodule // usr_rx_master_model

// ===== verif/usr_rx_checker.sv
// Purpose: port-level assertions for the receive port
// Assumes: one clock domain; enables shadowed from register writes
// Notes:   bound to usr_rx_top
`timescale 1ns/100ps

module usr_rx_checker
(
    input wire        clock,
    input wire        rst,
    input wire [7:0]  addr,
    input wire [7:0]  wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire [7:0]  rdata,
    input wire        transmit_clock_pin_out,
    input wire        transmit_clock_pin_oe,
    input wire        rx_wake,
    input wire        core_irq,
    input wire [12:0] irq_vector
);
    reg  clock_source_select_q;
    reg  receive_interrupt_enable_q;
    reg  gie_q;
    reg  peripheral_interrupt_enable_q;
    wire unmapped;

    assign unmapped = !(addr inside {8'h0b, 8'h0c, 8'h18, 8'h1a,
                                     8'h8c, 8'h98, 8'h99});

    // the checker sees writes only, so it keeps its own copy of enables
    always @(posedge clock)
    begin
        if (rst)
        begin
            clock_source_select_q <= 1'b0;
            receive_interrupt_enable_q <= 1'b0;
            gie_q  <= 1'b0;
            peripheral_interrupt_enable_q <= 1'b0;
        end
        else if (wr_en)
        begin
            if (addr == 8'h98)
                clock_source_select_q <= wdata[7];
            if (addr == 8'h8c)
                receive_interrupt_enable_q <= wdata[5];
            if (addr == 8'h0b)
            begin
                gie_q  <= wdata[7];
                peripheral_interrupt_enable_q <= wdata[6];
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rdata_idle_zero: assert property (
        !$past(rd_en) |-> rdata == 8'h00) else $error("rdata not idle");
    a_unmapped_reads_zero: assert property (
        $past(rd_en) && $past(unmapped) |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_tx_stat_ready: assert property (
        $past(rd_en) && $past(addr) == 8'h98 |-> rdata[1])
        else $error("transmit status bit1 low");
    a_read_clears_wake: assert property (
        rd_en && addr == 8'h1a |-> ##2 !rx_wake)
        else $error("wake kept after data read");
    a_wake_needs_enable: assert property (
        rx_wake |-> $past(receive_interrupt_enable_q)) else $error("wake while disabled");
    // wake and irq are registered side by side from the same next value
    a_irq_gating: assert property (
        core_irq == (rx_wake && $past(gie_q) && $past(peripheral_interrupt_enable_q)))
        else $error("core irq gating wrong");
    a_vector_with_irq: assert property (
        irq_vector == (core_irq ? 13'h0004 : 13'h0000))
        else $error("vector wrong");
    a_slave_no_drive: assert property (
        !$past(clock_source_select_q) |-> !transmit_clock_pin_oe)
        else $error("clock pin driven in slave mode");
    a_slave_clock_idle: assert property (
        !$past(clock_source_select_q, 2) |-> transmit_clock_pin_out)
        else $error("own shift clock runs in slave mode");
endmodule // usr_rx_checker

bind usr_rx_top usr_rx_checker i_usr_rx_checker (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .transmit_clock_pin_out(transmit_clock_pin_out),
    .transmit_clock_pin_oe(transmit_clock_pin_oe), .rx_wake(rx_wake),
    .core_irq(core_irq), .irq_vector(irq_vector));

// ===== verif/usr_rx_top_tb.sv
// Purpose: self-checking bench for the synchronous receive port
// Assumes: slave mode except test master_single, behavioural external master on the pins
// Notes:   9-bit words carry the ninth bit in bit 8
`timescale 1ns/100ps

`define CHK(a, e) \
    begin \
        compares = compares + 1; \
        if ((a) !== (e)) \
        begin \
            errors = errors + 1; \
            $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end

module usr_rx_top_tb;
    localparam [63:0] RA = 64'h0b0c181a8c989955;
    localparam [63:0] RV = 64'h0000000000020000;
    reg         clock;
    reg         rst;
    reg  [7:0]  addr;
    reg  [7:0]  wdata;
    reg         wr_en;
    reg         rd_en;
    reg         core_sleep;
    wire [7:0]  rdata;
    wire        ck_pin;
    wire        dt_pin;
    wire        rx_wake;
    wire        core_irq;
    wire [12:0] irq_vector;
    wire        pin_oe;
    wire        ck_out;
    integer     errors;
    integer     compares;
    integer     i;

    usr_rx_top i_usr_rx_top (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .transmit_clock_pin_in(ck_pin), .data_pin_in(dt_pin),
        .core_sleep(core_sleep), .transmit_clock_pin_out(ck_out),
        .transmit_clock_pin_oe(pin_oe), .rx_wake(rx_wake),
        .core_irq(core_irq), .irq_vector(irq_vector));

    usr_rx_master_model i_usr_rx_master_model (.ck(ck_pin), .dt(dt_pin));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    end
    endtask

    task chkrd(input [7:0] a, input [7:0] m, input [7:0] e);
        reg [7:0] d;
    begin
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata & m;
        `CHK(d, e)
    end
    endtask

    // flag, wake and irq land a few clocks after the last falling edge
    task word(input [8:0] w, input integer n);
    begin
        i_usr_rx_master_model.send(w, n);
        repeat (8) @(posedge clock);
        #1;
    end
    endtask

    task give_verdict;
    begin
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        errors = 0;
        compares = 0;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        core_sleep = 1'b0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        for (i = 7; i >= 0; i = i - 1)
            chkrd(RA[8*i+:8], 8'hff, RV[8*i+:8]);
        wr(8'h1a, 8'hff);
        chkrd(8'h1a, 8'hff, 8'h00);
        $display("test reset_values done");
        wr(8'h98, 8'h10);
        chkrd(8'h98, 8'hff, 8'h12);
        wr(8'h8c, 8'h20);
        wr(8'h0b, 8'hc0);
        wr(8'h18, 8'ha0);
        word(9'h0a5, 8);
        chkrd(8'h0c, 8'hff, 8'h00);
        `CHK(pin_oe, 1'b0)
        `CHK(ck_out, 1'b1)
        $display("test enable_gate done");
        @(posedge clock);
        core_sleep <= 1'b1;
        wr(8'h18, 8'hb0);
        word(9'h0a5, 8);
        `CHK(rx_wake, 1'b1)
        `CHK(core_irq, 1'b1)
        `CHK(irq_vector, 13'h0004)
        chkrd(8'h18, 8'hff, 8'hb0);
        chkrd(8'h1a, 8'hff, 8'ha5);
        @(posedge clock);
        core_sleep <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        `CHK(core_irq, 1'b0)
        $display("test sleep_receive done");
        wr(8'h18, 8'hd0);
        word(9'h13c, 9);
        chkrd(8'h0c, 8'hff, 8'h20);
        chkrd(8'h18, 8'hff, 8'hd1);
        chkrd(8'h1a, 8'hff, 8'h3c);
        $display("test ninth_bit done");
        word(9'h155, 9);
        word(9'h0aa, 9);
        chkrd(8'h18, 8'hff, 8'hd3);
        chkrd(8'h1a, 8'hff, 8'h55);
        wr(8'h18, 8'hc0);
        chkrd(8'h18, 8'hfe, 8'hc0);
        $display("test overrun done");
        wr(8'h18, 8'h90);
        wr(8'h0b, 8'h40);
        word(9'h081, 8);
        `CHK(rx_wake, 1'b1)
        `CHK(core_irq, 1'b0)
        chkrd(8'h0c, 8'hff, 8'h20);
        repeat (2) @(posedge clock);
        #1;
        `CHK(rx_wake, 1'b0)
        wr(8'h8c, 8'h00);
        word(9'h07e, 8);
        `CHK(rx_wake, 1'b0)
        chkrd(8'h1a, 8'hff, 8'h7e);
        $display("test masking done");
        // master mode: the port makes the clock, the data line stays high
        i_usr_rx_master_model.hold(1'b1);
        wr(8'h99, 8'h03);
        wr(8'h18, 8'ha0);
        wr(8'h98, 8'h90);
        repeat (100) @(posedge clock);
        #1;
        `CHK(pin_oe, 1'b1)
        `CHK(ck_out, 1'b1)
        chkrd(8'h0c, 8'hff, 8'h20);
        chkrd(8'h18, 8'hff, 8'h80);
        chkrd(8'h1a, 8'hff, 8'hff);
        $display("test master_single done");
        give_verdict;
    end

    // the whole run needs some 10 us; a normal run ends well before the limit
    initial
    begin
        #200000;
        errors = errors + 1;
        give_verdict;
    end
endmodule // usr_rx_top_tb
